// ===== bus_cmd_pkg.sv
// Overview of operation
// - Commands run only while the bus idles
// - Low four command bits select the command
// - Station setup stores twelve-bit own address
// - Condition bits 3:2 select bus speed mode
// - Condition bit 0 enables slave transmit block
// - Station settings held until reset mode
// - Station setup clears lock and buffer flags
// - Station setup enables reception, clears write FIFO
// - Target address stored, write FIFO then cleared
// - Master start begins frame to target unit
// - First start byte picks broadcast or ordinary
// - Second start byte gives control field
// - Third start byte counts bytes, zero means 256
// - Master resume restarts from interruption point
// - Resume reuses last start parameters
// - One frame, at most three arbitration attempts
// - No master frame before station setup
// - Wrong parameter count is never flagged
// - Lock read pushes status then lock address
// - Command bits valid only with bit 6 set
// - Receive control 00H disables, 01H enables
// - Abort empties write FIFO, cancels slave data
package bus_cmd_pkg;

  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_WFIFO = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_STATION = 8'h0C;
  localparam logic [7:0] ADDR_TARGET = 8'h10;
  localparam logic [7:0] ADDR_MASTER = 8'h14;
  localparam logic [7:0] ADDR_SLAVE = 8'h18;

  localparam int CMD_RESET_BIT = 7;
  localparam int CMD_VALID_BIT = 6;

  localparam logic [3:0] CODE_STATION = 4'h0;
  localparam logic [3:0] CODE_TARGET = 4'h1;
  localparam logic [3:0] CODE_START = 4'h2;
  localparam logic [3:0] CODE_RESUME = 4'h3;
  localparam logic [3:0] CODE_ABORT = 4'h4;
  localparam logic [3:0] CODE_SLAVE_DATA = 4'h5;
  localparam logic [3:0] CODE_LOCK_READ = 4'h6;
  localparam logic [3:0] CODE_RX_CTRL = 4'h7;

  localparam logic [1:0] NPAR_STATION = 2'd2;
  localparam logic [1:0] NPAR_TARGET = 2'd2;
  localparam logic [1:0] NPAR_START = 2'd3;
  localparam logic [1:0] NPAR_RX_CTRL = 2'd1;
  localparam logic [1:0] NPAR_NONE = 2'd0;
  localparam logic [1:0] NPUSH_LOCK = 2'd3;

  localparam int COND_MODE_HI = 3;
  localparam int COND_MODE_LO = 2;
  localparam int COND_SLAVE_TX = 0;
  localparam logic [3:0] BCAST_ORDINARY = 4'h8;
  localparam logic [7:0] RX_DISABLE = 8'h00;
  localparam logic [7:0] RX_ENABLE = 8'h01;
  localparam logic [7:0] LOCKED_BYTE = 8'h01;
  localparam logic [7:0] UNLOCKED_BYTE = 8'h00;
  localparam logic [1:0] MAX_ATTEMPTS = 2'd3;

  localparam int WFIFO_WIDTH = 8;
  localparam int WFIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_POP,
    ST_TAKE,
    ST_EXEC,
    ST_PUSH
  } cmd_state_e;

endpackage

// ===== byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  // Status and data
  output logic [WIDTH-1:0] pop_data,
  output logic full,
  output logic empty
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST = (PW)'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] count_ff;
  logic [WIDTH-1:0] pop_data_ff;
  wire do_push = push && !full;
  wire do_pop = pop && !empty;
  wire [PW-1:0] nxt_wr_ptr = (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
  wire [PW-1:0] nxt_rd_ptr = (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;

  assign full = (count_ff == DEPTH_CNT);
  assign empty = (count_ff == '0);
  assign pop_data = pop_data_ff;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= push_data;
    end
  end

  // Popped word appears in the register on the cycle after the pop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      pop_data_ff <= '0;
    end else if (clear) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= nxt_wr_ptr;
      end
      if (do_pop) begin
        rd_ptr_ff <= nxt_rd_ptr;
        pop_data_ff <= mem_ff[rd_ptr_ff];
      end
      if (do_push && !do_pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_pop && !do_push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bus_comm_command_decoder.sv
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bus_comm_command_decoder (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link engine status, same clock
  input wire logic bus_busy,
  input wire logic arb_lost,
  input wire logic frame_done,
  input wire logic frame_cut,
  input wire logic lock_set,
  input wire logic [11:0] lock_addr,
  input wire logic link_pop,
  // Settings towards the link engine
  output logic reset_mode,
  output logic [11:0] own_addr,
  output logic [1:0] speed_mode,
  output logic slave_tx_en,
  output logic rx_enable,
  output logic [11:0] target_addr,
  output logic slave_data_valid,
  // Master frame requests
  output logic master_go,
  output logic master_resume,
  output logic bcast_bit,
  output logic [3:0] ctrl_field,
  output logic [7:0] byte_count,
  // Transmit data from the write FIFO
  output logic [7:0] tx_data,
  output logic wfifo_empty,
  // Read FIFO push port
  input wire logic rfifo_ready,
  output logic rfifo_push,
  output logic [7:0] rfifo_data
);
  bus_cmd_pkg::cmd_state_e state_ff, nxt_state;

  logic [7:0] command_reg_ff;
  logic reset_mode_ff;
  logic pending_ff;
  logic [3:0] code_ff;
  logic [1:0] nparams_ff;
  logic [1:0] idx_ff, nxt_idx;
  logic popped_ff;
  logic [7:0] par0_ff, par1_ff, par2_ff;
  logic [11:0] own_addr_ff, target_addr_ff;
  logic [1:0] speed_mode_ff;
  logic slave_tx_en_ff, rx_enable_ff, init_done_ff;
  logic slave_data_valid_ff, locked_ff;
  logic [3:0] bcast_ff, ctrl_ff;
  logic [7:0] count_ff;
  logic master_active_ff, interrupted_ff, master_fail_ff;
  logic [1:0] attempts_ff;
  logic master_go_ff, master_resume_ff;
  logic rfifo_push_ff;
  logic [7:0] rfifo_data_ff, prdata_ff;
  logic wfifo_full;

  // APB decode
  wire apb_setup = psel && !penable;
  wire hit_cmd = (paddr == bus_cmd_pkg::ADDR_COMMAND);
  wire hit_wfifo = (paddr == bus_cmd_pkg::ADDR_WFIFO);
  wire hit_state = (paddr == bus_cmd_pkg::ADDR_STATE);
  wire hit_station = (paddr == bus_cmd_pkg::ADDR_STATION);
  wire hit_target = (paddr == bus_cmd_pkg::ADDR_TARGET);
  wire hit_master = (paddr == bus_cmd_pkg::ADDR_MASTER);
  wire hit_slave = (paddr == bus_cmd_pkg::ADDR_SLAVE);
  wire hit_any = hit_cmd | hit_wfifo | hit_state | hit_station | hit_target
                 | hit_master | hit_slave;
  // A byte written into a full write FIFO stalls the bus until a slot frees
  wire wfifo_stall = psel && penable && pwrite && hit_wfifo && wfifo_full;
  wire apb_done = psel && penable && pready;
  wire cmd_wr = apb_done && pwrite && hit_cmd;
  wire wfifo_wr = apb_done && pwrite && hit_wfifo;
  wire cmd_valid_wr = cmd_wr && pwdata[bus_cmd_pkg::CMD_VALID_BIT]
                      && !pwdata[bus_cmd_pkg::CMD_RESET_BIT];

  assign pready = !wfifo_stall;
  assign pslverr = psel && penable && !hit_any;

  wire [7:0] slave_status = {1'b1, 2'b00, slave_tx_en_ff, 1'b0, locked_ff,
                             !rx_enable_ff, slave_data_valid_ff};
  wire [31:0] rd_word =
    hit_cmd ? {24'h000000, command_reg_ff} :
    hit_state ? {24'h000000, master_fail_ff, interrupted_ff, master_active_ff,
                 init_done_ff, pending_ff, reset_mode_ff, wfifo_empty, wfifo_full} :
    hit_station ? {16'h0000, slave_tx_en_ff, 1'b0, speed_mode_ff, own_addr_ff} :
    hit_target ? {20'h00000, target_addr_ff} :
    hit_master ? {16'h0000, bcast_ff, ctrl_ff, count_ff} :
    hit_slave ? {24'h000000, slave_status} :
    32'h00000000;

  // Read data is latched in the setup phase so it stands through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 8'h00;
    end else if (apb_setup && !pwrite) begin
      prdata_ff <= rd_word[7:0];
    end
  end

  // Upper read bits kept in a second register to keep data from flip-flops
  logic [23:0] prdata_hi_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_hi_ff <= 24'h000000;
    end else if (apb_setup && !pwrite) begin
      prdata_hi_ff <= rd_word[31:8];
    end
  end
  assign prdata = {prdata_hi_ff, prdata_ff};

  // Command register, reset mode and pending command
  wire take_cmd = (state_ff == bus_cmd_pkg::ST_IDLE) && pending_ff && !bus_busy;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_reg_ff <= 8'h00;
      reset_mode_ff <= 1'b1;
      pending_ff <= 1'b0;
      code_ff <= 4'h0;
    end else begin
      if (cmd_wr) begin
        command_reg_ff <= pwdata[7:0];
        reset_mode_ff <= pwdata[bus_cmd_pkg::CMD_RESET_BIT];
      end
      // A new command write wins over the take of the previous one
      if (cmd_valid_wr) begin
        pending_ff <= 1'b1;
        code_ff <= pwdata[3:0];
      end else if (take_cmd || reset_mode_ff) begin
        pending_ff <= 1'b0;
      end
    end
  end

  // Parameter count per command; short FIFO contents read as zero bytes
  wire [1:0] npar_of_code =
    (code_ff == bus_cmd_pkg::CODE_STATION) ? bus_cmd_pkg::NPAR_STATION :
    (code_ff == bus_cmd_pkg::CODE_TARGET) ? bus_cmd_pkg::NPAR_TARGET :
    (code_ff == bus_cmd_pkg::CODE_START) ? bus_cmd_pkg::NPAR_START :
    (code_ff == bus_cmd_pkg::CODE_RX_CTRL) ? bus_cmd_pkg::NPAR_RX_CTRL :
    bus_cmd_pkg::NPAR_NONE;

  wire in_pop = (state_ff == bus_cmd_pkg::ST_POP);
  wire in_exec = (state_ff == bus_cmd_pkg::ST_EXEC);
  wire in_push = (state_ff == bus_cmd_pkg::ST_PUSH);
  wire fsm_pop = in_pop && !wfifo_empty;
  wire [7:0] fifo_byte = popped_ff ? tx_data : 8'h00;
  wire [1:0] idx_inc = idx_ff + 2'd1;
  wire is_code_station = (code_ff == bus_cmd_pkg::CODE_STATION);
  wire is_code_target = (code_ff == bus_cmd_pkg::CODE_TARGET);
  wire is_code_start = (code_ff == bus_cmd_pkg::CODE_START);
  wire is_code_resume = (code_ff == bus_cmd_pkg::CODE_RESUME);
  wire is_code_abort = (code_ff == bus_cmd_pkg::CODE_ABORT);
  wire is_code_sdata = (code_ff == bus_cmd_pkg::CODE_SLAVE_DATA);
  wire is_code_lock = (code_ff == bus_cmd_pkg::CODE_LOCK_READ);
  wire is_code_rx = (code_ff == bus_cmd_pkg::CODE_RX_CTRL);
  wire exec_station = in_exec && is_code_station;
  wire exec_target = in_exec && is_code_target;
  wire exec_start = in_exec && is_code_start && init_done_ff;
  wire exec_resume = in_exec && is_code_resume && init_done_ff;
  wire exec_rx = in_exec && is_code_rx;
  wire exec_abort = in_exec && is_code_abort;
  wire push_fire = in_push && rfifo_ready;
  wire wfifo_clear = reset_mode_ff || exec_abort
                     || exec_station || exec_target || exec_rx;

  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    case (state_ff)
      bus_cmd_pkg::ST_IDLE: begin
        if (take_cmd) begin
          nxt_idx = 2'd0;
          nxt_state = (npar_of_code == bus_cmd_pkg::NPAR_NONE) ?
                      bus_cmd_pkg::ST_EXEC : bus_cmd_pkg::ST_POP;
        end
      end
      bus_cmd_pkg::ST_POP: begin
        nxt_state = bus_cmd_pkg::ST_TAKE;
      end
      bus_cmd_pkg::ST_TAKE: begin
        nxt_idx = idx_inc;
        nxt_state = (idx_inc == nparams_ff) ? bus_cmd_pkg::ST_EXEC : bus_cmd_pkg::ST_POP;
      end
      bus_cmd_pkg::ST_EXEC: begin
        nxt_idx = 2'd0;
        nxt_state = is_code_lock ? bus_cmd_pkg::ST_PUSH : bus_cmd_pkg::ST_IDLE;
      end
      bus_cmd_pkg::ST_PUSH: begin
        if (push_fire) begin
          nxt_idx = idx_inc;
          if (idx_inc == bus_cmd_pkg::NPUSH_LOCK) begin
            nxt_state = bus_cmd_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        nxt_state = bus_cmd_pkg::ST_IDLE;
        nxt_idx = 2'd0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= bus_cmd_pkg::ST_IDLE;
      idx_ff <= 2'd0;
      nparams_ff <= 2'd0;
      popped_ff <= 1'b0;
    end else if (reset_mode_ff) begin
      state_ff <= bus_cmd_pkg::ST_IDLE;
      idx_ff <= 2'd0;
      popped_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      popped_ff <= fsm_pop;
      if (take_cmd) begin
        nparams_ff <= npar_of_code;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par0_ff <= 8'h00;
      par1_ff <= 8'h00;
      par2_ff <= 8'h00;
    end else if (state_ff == bus_cmd_pkg::ST_TAKE) begin
      case (idx_ff)
        2'd0: par0_ff <= fifo_byte;
        2'd1: par1_ff <= fifo_byte;
        default: par2_ff <= fifo_byte;
      endcase
    end
  end

  // Station and target settings survive until reset mode is entered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_addr_ff <= 12'h000;
      speed_mode_ff <= 2'b00;
      slave_tx_en_ff <= 1'b0;
      init_done_ff <= 1'b0;
      target_addr_ff <= 12'h000;
      rx_enable_ff <= 1'b0;
    end else if (reset_mode_ff) begin
      own_addr_ff <= 12'h000;
      speed_mode_ff <= 2'b00;
      slave_tx_en_ff <= 1'b0;
      init_done_ff <= 1'b0;
      target_addr_ff <= 12'h000;
      rx_enable_ff <= 1'b0;
    end else if (in_exec) begin
      if (is_code_station) begin
        own_addr_ff <= {par0_ff, par1_ff[7:4]};
        speed_mode_ff <= par1_ff[bus_cmd_pkg::COND_MODE_HI:bus_cmd_pkg::COND_MODE_LO];
        slave_tx_en_ff <= par1_ff[bus_cmd_pkg::COND_SLAVE_TX];
        init_done_ff <= 1'b1;
      end
      if (is_code_target) begin
        target_addr_ff <= {par0_ff, par1_ff[7:4]};
      end
      // Receive control sets the state; every other command except lock read re-enables
      if (is_code_rx) begin
        if (par0_ff == bus_cmd_pkg::RX_DISABLE) begin
          rx_enable_ff <= 1'b0;
        end else if (par0_ff == bus_cmd_pkg::RX_ENABLE) begin
          rx_enable_ff <= 1'b1;
        end
      end else if (!is_code_lock) begin
        rx_enable_ff <= 1'b1;
      end
    end
  end

  // Slave status flags; a lock event wins over a station setup clear in the same cycle, reset mode wins over both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_ff <= 1'b0;
      slave_data_valid_ff <= 1'b0;
    end else if (reset_mode_ff) begin
      locked_ff <= 1'b0;
      slave_data_valid_ff <= 1'b0;
    end else begin
      if (lock_set) begin
        locked_ff <= 1'b1;
      end else if (exec_station) begin
        locked_ff <= 1'b0;
      end
      if (in_exec && is_code_sdata) begin
        slave_data_valid_ff <= 1'b1;
      end else if (exec_station || exec_abort) begin
        slave_data_valid_ff <= 1'b0;
      end
    end
  end

  // Master frame parameters and arbitration retries
  wire can_retry = (attempts_ff < bus_cmd_pkg::MAX_ATTEMPTS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcast_ff <= 4'h0;
      ctrl_ff <= 4'h0;
      count_ff <= 8'h00;
      master_active_ff <= 1'b0;
      interrupted_ff <= 1'b0;
      master_fail_ff <= 1'b0;
      attempts_ff <= 2'd0;
      master_go_ff <= 1'b0;
      master_resume_ff <= 1'b0;
    end else if (reset_mode_ff) begin
      bcast_ff <= 4'h0;
      ctrl_ff <= 4'h0;
      count_ff <= 8'h00;
      master_active_ff <= 1'b0;
      interrupted_ff <= 1'b0;
      master_fail_ff <= 1'b0;
      attempts_ff <= 2'd0;
      master_go_ff <= 1'b0;
      master_resume_ff <= 1'b0;
    end else begin
      master_go_ff <= 1'b0;
      master_resume_ff <= 1'b0;
      if (exec_start) begin
        bcast_ff <= par0_ff[3:0];
        ctrl_ff <= par1_ff[3:0];
        count_ff <= par2_ff;
        master_go_ff <= 1'b1;
        master_active_ff <= 1'b1;
        interrupted_ff <= 1'b0;
        master_fail_ff <= 1'b0;
        attempts_ff <= 2'd1;
      end else if (exec_resume) begin
        master_resume_ff <= 1'b1;
        master_active_ff <= 1'b1;
        interrupted_ff <= 1'b0;
        master_fail_ff <= 1'b0;
        attempts_ff <= 2'd1;
      end else if (master_active_ff) begin
        if (arb_lost) begin
          if (can_retry) begin
            master_go_ff <= !interrupted_ff;
            master_resume_ff <= interrupted_ff;
            attempts_ff <= attempts_ff + 2'd1;
          end else begin
            master_active_ff <= 1'b0;
            master_fail_ff <= 1'b1;
          end
        end else if (frame_cut) begin
          master_active_ff <= 1'b0;
          interrupted_ff <= 1'b1;
        end else if (frame_done) begin
          master_active_ff <= 1'b0;
        end
      end
      // Any other command after a cut frame spoils the resume point
      if (in_exec && !is_code_resume && !is_code_start && !frame_cut) begin
        interrupted_ff <= 1'b0;
      end
    end
  end

  // Lock read result: status byte, then address high nibble, then low byte
  wire [7:0] lock_byte = locked_ff ? bus_cmd_pkg::LOCKED_BYTE : bus_cmd_pkg::UNLOCKED_BYTE;
  wire [7:0] push_byte = (idx_ff == 2'd0) ? lock_byte :
                         (idx_ff == 2'd1) ? {4'h0, lock_addr[11:8]} : lock_addr[7:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rfifo_push_ff <= 1'b0;
      rfifo_data_ff <= 8'h00;
    end else begin
      rfifo_push_ff <= push_fire;
      if (push_fire) begin
        rfifo_data_ff <= push_byte;
      end
    end
  end

  byte_fifo #(
    .WIDTH(bus_cmd_pkg::WFIFO_WIDTH),
    .DEPTH(bus_cmd_pkg::WFIFO_DEPTH)
  ) u_write_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .clear(wfifo_clear),
    .push(wfifo_wr),
    .push_data(pwdata[7:0]),
    .pop(fsm_pop || link_pop),
    .pop_data(tx_data),
    .full(wfifo_full),
    .empty(wfifo_empty)
  );

  assign reset_mode = reset_mode_ff;
  assign own_addr = own_addr_ff;
  assign speed_mode = speed_mode_ff;
  assign slave_tx_en = slave_tx_en_ff;
  assign rx_enable = rx_enable_ff;
  assign target_addr = target_addr_ff;
  assign slave_data_valid = slave_data_valid_ff;
  assign master_go = master_go_ff;
  assign master_resume = master_resume_ff;
  assign bcast_bit = (bcast_ff == bus_cmd_pkg::BCAST_ORDINARY);
  assign ctrl_field = ctrl_ff;
  assign byte_count = count_ff;
  assign rfifo_push = rfifo_push_ff;
  assign rfifo_data = rfifo_data_ff;
endmodule
`default_nettype wire

// ===== bus_comm_command_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
module bus_comm_command_decoder_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link status
  input wire logic bus_busy,
  input wire logic arb_lost,
  input wire logic [11:0] lock_addr,
  // Settings and frame requests
  input wire logic reset_mode,
  input wire logic [11:0] own_addr,
  input wire logic [1:0] speed_mode,
  input wire logic slave_tx_en,
  input wire logic [11:0] target_addr,
  input wire logic master_go,
  input wire logic master_resume,
  input wire logic [3:0] ctrl_field,
  input wire logic [7:0] byte_count,
  input wire logic rfifo_push,
  input wire logic [7:0] rfifo_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] tries_ff;
  logic lost_ff;
  wire logic start = master_go || master_resume;
  // A start right after a loss is a retry; any other start opens a new count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tries_ff <= 3'h0;
      lost_ff <= 1'b0;
    end else begin
      lost_ff <= arb_lost;
      if (start) tries_ff <= lost_ff ? tries_ff + 3'h1 : 3'h1;
    end
  end
  sequence s_lock_addr;
    rfifo_push && rfifo_data == {4'h0, lock_addr[11:8]} ##1
    rfifo_push && rfifo_data == lock_addr[7:0];
  endsequence
  a_idle_hold: assert property (bus_busy && $past(bus_busy) |->
    $stable(own_addr) && $stable(target_addr)) else $error("setting changed while busy");
  a_reset_clear: assert property (reset_mode && $past(reset_mode) |->
    own_addr == 12'h000 && speed_mode == 2'h0 && !slave_tx_en) else $error("station kept");
  a_target_clear: assert property (reset_mode && $past(reset_mode) |->
    target_addr == 12'h000) else $error("target kept in reset mode");
  a_retry_follow: assert property (arb_lost && tries_ff < 3'h3 |=> start)
    else $error("no retry after loss");
  a_no_fourth: assert property (arb_lost && tries_ff == 3'h3 |=> !start)
    else $error("fourth attempt");
  a_resume_reuse: assert property (master_resume |->
    $stable(ctrl_field) && $stable(byte_count)) else $error("resume changed frame");
  a_no_master_reset: assert property (reset_mode |-> !start)
    else $error("master frame without setup");
  a_lock_order: assert property ($rose(rfifo_push) |->
    rfifo_data[7:1] == 7'h00 ##1 s_lock_addr) else $error("lock bytes wrong");
endmodule
`default_nettype wire

// ===== link_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_engine_model #(
  parameter logic [11:0] LOCK_ADDR = 12'hABC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Scenario controls
  input wire logic busy_req,
  input wire logic [1:0] lose_n,
  input wire logic cut_req,
  input wire logic lock_req,
  // Decoder side
  input wire logic master_go,
  input wire logic master_resume,
  input wire logic wfifo_empty,
  input wire logic rfifo_push,
  input wire logic [7:0] rfifo_data,
  output logic bus_busy,
  output logic arb_lost,
  output logic frame_done,
  output logic frame_cut,
  output logic lock_set,
  output logic [11:0] lock_addr,
  output logic link_pop,
  output logic rfifo_ready,
  // Observation
  output logic [7:0] go_cnt,
  output logic [23:0] rx_log
);
  logic start_ff;
  logic [1:0] losses_ff;
  wire logic won = losses_ff >= lose_n;
  assign bus_busy = busy_req;
  assign lock_addr = LOCK_ADDR;
  assign rfifo_ready = 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {start_ff, losses_ff, arb_lost, frame_done, frame_cut, lock_set, link_pop} <= '0;
      go_cnt <= 8'h00;
      rx_log <= 24'h000000;
    end else begin
      start_ff <= master_go || master_resume;
      lock_set <= lock_req;
      arb_lost <= start_ff && !won;
      frame_cut <= start_ff && won && cut_req;
      frame_done <= start_ff && won && !cut_req;
      link_pop <= start_ff && !wfifo_empty;
      if (start_ff) losses_ff <= won ? 2'h0 : losses_ff + 2'h1;
      if (master_go || master_resume) go_cnt <= go_cnt + 8'h01;
      if (rfifo_push) rx_log <= {rx_log[15:0], rfifo_data};
    end
  end
endmodule
`default_nettype wire

// ===== bus_comm_command_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module bus_comm_command_decoder_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
  logic [7:0] paddr, byte_count, tx_data, rfifo_data, go_cnt;
  logic [31:0] pwdata, prdata, rd_data;
  logic bus_busy, arb_lost, frame_done, frame_cut, lock_set, link_pop, rfifo_ready;
  logic [11:0] lock_addr, own_addr, target_addr;
  logic reset_mode, slave_tx_en, rx_enable, slave_data_valid, master_go, master_resume;
  logic bcast_bit, wfifo_empty, rfifo_push, busy_req, cut_req, lock_req;
  logic [1:0] speed_mode, lose_n;
  logic [3:0] ctrl_field;
  logic [23:0] rx_log;
  int mismatches, samples_checked;
  bus_comm_command_decoder DUT (.*);
  link_engine_model partner (.*);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h000000, data};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    do begin
      apb(1'b0, 8'h08, 8'h00);
    end while (rd_data[3] !== 1'b0);
    repeat (20) @(posedge pclk);
  endtask
  task automatic cmd(input logic [7:0] code);
    apb(1'b1, 8'h00, code);
    settle();
  endtask
  task automatic p2(input logic [15:0] w);
    apb(1'b1, 8'h04, w[15:8]);
    apb(1'b1, 8'h04, w[7:0]);
  endtask
  task automatic p3(input logic [23:0] w);
    apb(1'b1, 8'h04, w[23:16]);
    p2(w[15:0]);
  endtask
  task automatic t_reset;
    apb(1'b0, 8'h08, 8'h00);
    chk("state", rd_data, 32'h06);
    apb(1'b1, 8'h00, 8'h00);
    @(posedge pclk);
    chk("reset_mode", 32'(reset_mode), 32'h0);
    p3(24'h080A04);
    cmd(8'h42);
    chk("go", 32'(go_cnt), 32'h0);
  endtask
  task automatic t_station(input logic [3:0] c);
    p2({12'h012, c});
    cmd(8'h40);
    chk("own", 32'({own_addr, speed_mode, slave_tx_en}), {17'h0, 12'h012, c[3:2], c[0]});
    chk("rx", 32'({rx_enable, wfifo_empty}), 32'h3);
    apb(1'b0, 8'h18, 8'h00);
    chk("slave", rd_data, {24'h0, 3'h4, c[0], 4'h0});
  endtask
  task automatic t_target;
    p2(16'h0240);
    cmd(8'h41);
    chk("target", 32'({target_addr, wfifo_empty}), 32'h049);
    cmd(8'h01);
    chk("target", 32'(target_addr), 32'h024);
  endtask
  task automatic t_busy;
    busy_req <= 1'b1;
    p3(24'h080A04);
    apb(1'b1, 8'h04, 8'h12);
    apb(1'b1, 8'h00, 8'h42);
    repeat (30) @(posedge pclk);
    chk("go", 32'(go_cnt), 32'h0);
    busy_req <= 1'b0;
    settle();
    chk("go", 32'(go_cnt), 32'h1);
    chk("frame", 32'({bcast_bit, ctrl_field, byte_count, tx_data, wfifo_empty}), 32'h340825);
    apb(1'b1, 8'h04, 8'h34);
    cmd(8'h44);
    chk("empty", 32'(wfifo_empty), 32'h1);
  endtask
  task automatic t_retry;
    lose_n <= 2'h3;
    p3(24'h000500);
    cmd(8'h42);
    apb(1'b0, 8'h08, 8'h00);
    chk("fail", 32'({go_cnt, rd_data[7]}), 32'h9);
    chk("frame", 32'({bcast_bit, ctrl_field, byte_count}), 32'h0500);
    lose_n <= 2'h0;
    cut_req <= 1'b1;
    p3(24'h08030C);
    cmd(8'h42);
    apb(1'b0, 8'h08, 8'h00);
    chk("cut", 32'(rd_data[6]), 32'h1);
    cut_req <= 1'b0;
    cmd(8'h43);
    chk("go", 32'(go_cnt), 32'h6);
    chk("frame", 32'({bcast_bit, ctrl_field, byte_count}), 32'h130C);
  endtask
  task automatic t_lock;
    lock_req <= 1'b1;
    @(posedge pclk);
    lock_req <= 1'b0;
    apb(1'b1, 8'h04, 8'h00);
    cmd(8'h47);
    apb(1'b0, 8'h18, 8'h00);
    chk("slave", {rd_data[30:0], rx_enable}, 32'h12C);
    cmd(8'h46);
    chk("lock", 32'(rx_log), 32'h010ABC);
    apb(1'b1, 8'h04, 8'h01);
    cmd(8'h47);
    chk("rx", 32'(rx_enable), 32'h1);
  endtask
  task automatic t_abort;
    p2(16'h0155);
    cmd(8'h45);
    chk("sdata", 32'(slave_data_valid), 32'h1);
    cmd(8'h44);
    chk("sdata", 32'({slave_data_valid, wfifo_empty}), 32'h1);
    apb(1'b0, 8'h1C, 8'h00);
    chk("slverr", 32'({rd_err, rd_data[7:0]}), 32'h100);
    t_station(4'h0);
    apb(1'b1, 8'h00, 8'h80);
    repeat (2) @(posedge pclk);
    chk("soft", 32'({reset_mode, own_addr, target_addr}), 32'h1000000);
  endtask
  initial begin
    {psel, penable, pwrite, busy_req, cut_req, lock_req} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lose_n = 2'h0;
    presetn = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_station(4'h5);
    t_target();
    t_busy();
    t_retry();
    t_lock();
    t_station(4'h8);
    t_abort();
    test_done();
  end
  // Whole run needs about six hundred cycles
  initial begin
    repeat (8000) @(posedge pclk);
    mismatches++;
    test_done();
  end
endmodule
bind bus_comm_command_decoder bus_comm_command_decoder_properties props (.*);
`default_nettype wire
